// [core/sfo_defines.svh]
// Purpose: Constants for the safety field output controller.
// Assumes: 25 MHz clk; APB byte addresses below.
// Notes: Operation list follows.
// Operation
// - Boot state left only to ready or fault
// - Readiness no earlier than one minute; green lamp
// - Auto monitoring once ready, unit ok high
// - Host write drops unit ok about one second
// - Internal error: fault state, unit ok low
// - Infringed field output off within two scans
// - Unrequested output off within fifteen scans
// - Unit ok off over threshold: third state
// - Monitoring reports objects in active fields
// - Three fields, three active-low outputs
// - New field set evaluated within two scans
// - Sixteen sets chosen by four inputs
// - Switching outputs use active-low logic
// - Empty field holds output low until redefined
// - Index pulse on unit ok by default
// - Parameters live at once; store on commit
// - Field geometry applies only on push
// - Response time defaults to minimum
// - Blanking size defaults to minimum
// - Release after hold time, default maximum
// - Particle filter defaults off
// - Contour learning defaults off
// - Inputs binary, first input least significant
// - Inputs debounced, high active by default
// - Index as short low pulses at 90 degrees
// - All fields infringed outside monitoring and configuration
`ifndef SFO_DEFINES_SVH
`define SFO_DEFINES_SVH
`define SFO_CLK_HZ 25000000
`define SFO_MS_CYC (`SFO_CLK_HZ / 1000)
`define SFO_READY_MIN 1
`define SFO_READY_CYC (`SFO_READY_MIN * 60 * `SFO_CLK_HZ)
`define SFO_WRLOW_S 1
`define SFO_WRLOW_CYC (`SFO_WRLOW_S * `SFO_CLK_HZ)
`define SFO_DEBOUNCE_MS 10
`define SFO_DEBOUNCE_CYC (`SFO_DEBOUNCE_MS * `SFO_MS_CYC)
`define SFO_INDEX_MS 1
`define SFO_INDEX_CYC (`SFO_INDEX_MS * `SFO_MS_CYC)
`define SFO_OKLOW_MS 16'd67
`define SFO_RESP_DEF 16'd67
`define SFO_BLANK_DEF 16'd10
`define SFO_HOLD_DEF 16'd10050
`define SFO_OFF_CTRL 12'h000
`define SFO_OFF_RESP 12'h004
`define SFO_OFF_BLANK 12'h008
`define SFO_OFF_HOLD 12'h00c
`define SFO_OFF_FDEF 12'h010
`define SFO_OFF_STAT 12'h014
`define SFO_B_FILT 0
`define SFO_B_LEARN 1
`define SFO_B_INDEX 2
`define SFO_B_COMMIT 3
`define SFO_B_PUSH 4
`define SFO_B_INLOW 5
`endif

// [core/sfo_pkg.sv]
// Purpose: Types for the safety field output controller.
// Assumes: Constants live in sfo_defines.svh.
// Notes: One-hot operating states.
package sfo_pkg;
  typedef enum logic [4:0] {
    ST_BOOT = 5'h01,
    ST_READY = 5'h02,
    ST_MON = 5'h04,
    ST_CFG = 5'h08,
    ST_FAULT = 5'h10
  } sfo_state_t;

  typedef struct packed {
    logic in_low_active;
    logic index_en;
    logic learn_en;
    logic filter_en;
    logic [15:0] resp_ms;
    logic [15:0] blank_mm;
    logic [15:0] hold_ms;
  } sfo_cfg_t;
endpackage

// [core/sfo_field_ctrl.sv]
// Purpose: Operating states, field outputs and unit ok output with APB registers.
// Assumes: Scan and hit inputs come from the measurement core on clk.
// Notes: APB answers with zero wait states; reads and writes of unmapped addresses both give pslverr.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "sfo_defines.svh"
module sfo_field_ctrl #(
  parameter int unsigned READY_CYC = `SFO_READY_CYC,
  parameter int unsigned WRLOW_CYC = `SFO_WRLOW_CYC,
  parameter int unsigned DEBOUNCE_CYC = `SFO_DEBOUNCE_CYC,
  parameter int unsigned MS_CYC = `SFO_MS_CYC,
  parameter int unsigned INDEX_CYC = `SFO_INDEX_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic set_select_bit0,
  input wire logic set_select_bit1,
  input wire logic set_select_bit2,
  input wire logic set_select_bit3,
  input wire logic boot_done,
  input wire logic internal_error,
  input wire logic host_attached,
  input wire logic scan_tick,
  input wire logic index_tick,
  input wire logic [2:0] field_hit,
  output logic [3:0] active_set,
  output sfo_pkg::sfo_cfg_t cfg,
  output logic nvm_commit,
  output logic inner_field_alarm_output,
  output logic middle_field_alarm_output,
  output logic outer_field_alarm_output,
  output logic unit_ok_output,
  output logic ready_led,
  output logic fault_led,
  output logic defined_state3
);
  sfo_pkg::sfo_state_t state_r;
  sfo_pkg::sfo_cfg_t cfg_r;
  logic [47:0] pend_def_r;
  logic [47:0] act_def_r;
  logic [31:0] ready_cnt_r;
  logic ready_done_r;
  logic ok_base_r;
  logic [31:0] wrlow_cnt_r;
  logic [31:0] idx_cnt_r;
  logic [31:0] ms_cnt_r;
  logic ms_tick;
  logic [15:0] oklow_ms_r;
  logic [3:0] sel_code;
  logic [2:0] alarm_r;
  logic [2:0] out_r;
  logic [2:0] cur_def;
  logic wr_en;
  logic host_wr;
  logic commit_r;
  logic push_r;
  assign wr_en = psel & penable & pwrite;
  assign host_wr = wr_en & host_attached;
  assign pready = 1'b1;
  assign cfg = cfg_r;
  assign nvm_commit = commit_r;

  // APB write side; parameters act immediately
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r.filter_en <= 1'b0;
      cfg_r.learn_en <= 1'b0;
      cfg_r.index_en <= 1'b1;
      cfg_r.in_low_active <= 1'b0;
      cfg_r.resp_ms <= `SFO_RESP_DEF;
      cfg_r.blank_mm <= `SFO_BLANK_DEF;
      cfg_r.hold_ms <= `SFO_HOLD_DEF;
      pend_def_r <= 48'h0;
      commit_r <= 1'b0;
      push_r <= 1'b0;
    end else begin
      commit_r <= 1'b0;
      push_r <= 1'b0;
      if (wr_en) begin
        if (paddr == `SFO_OFF_CTRL) begin
          cfg_r.filter_en <= pwdata[`SFO_B_FILT];
          cfg_r.learn_en <= pwdata[`SFO_B_LEARN];
          cfg_r.index_en <= pwdata[`SFO_B_INDEX];
          cfg_r.in_low_active <= pwdata[`SFO_B_INLOW];
          commit_r <= pwdata[`SFO_B_COMMIT];
          push_r <= pwdata[`SFO_B_PUSH];
        end else if (paddr == `SFO_OFF_RESP) begin
          cfg_r.resp_ms <= pwdata[15:0];
        end else if (paddr == `SFO_OFF_BLANK) begin
          cfg_r.blank_mm <= pwdata[15:0];
        end else if (paddr == `SFO_OFF_HOLD) begin
          cfg_r.hold_ms <= pwdata[15:0];
        end else if (paddr == `SFO_OFF_FDEF) begin
          pend_def_r[pwdata[3:0]*3 +: 3] <= pwdata[6:4];
        end
      end
    end
  end

  // Geometry waits in the pending copy until pushed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_def_r <= 48'h0;
    end else if (push_r) begin
      act_def_r <= pend_def_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        if (paddr == `SFO_OFF_CTRL) begin
          prdata <= {26'h0, cfg_r.in_low_active, 2'b00, cfg_r.index_en,
                     cfg_r.learn_en, cfg_r.filter_en};
        end else if (paddr == `SFO_OFF_RESP) begin
          prdata <= {16'h0, cfg_r.resp_ms};
        end else if (paddr == `SFO_OFF_BLANK) begin
          prdata <= {16'h0, cfg_r.blank_mm};
        end else if (paddr == `SFO_OFF_HOLD) begin
          prdata <= {16'h0, cfg_r.hold_ms};
        end else if (paddr == `SFO_OFF_FDEF) begin
          prdata <= {25'h0, pend_def_r[2:0], 4'h0};
        end else if (paddr == `SFO_OFF_STAT) begin
          prdata <= {12'h0, defined_state3, unit_ok_output, out_r, active_set,
                     cur_def, 3'h0, state_r};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Set select inputs: two-stage sync then debounce
  logic [3:0] sel_pin;
  assign sel_pin = {set_select_bit3, set_select_bit2, set_select_bit1, set_select_bit0};
  for (genvar g = 0; g < 4; g++) begin : g_deb
    logic s1_r;
    logic s2_r;
    logic stab_r;
    logic [31:0] cnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
      end else begin
        s1_r <= sel_pin[g];
        s2_r <= s1_r;
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stab_r <= 1'b0;
        cnt_r <= 32'h0;
      end else if (s2_r == stab_r) begin
        cnt_r <= 32'h0;
      end else if (cnt_r >= DEBOUNCE_CYC - 1) begin
        stab_r <= s2_r;
        cnt_r <= 32'h0;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
    assign sel_code[g] = stab_r ^ cfg_r.in_low_active;
  end

  // Set change taken at the scan boundary, so the next scan uses it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_set <= 4'h0;
    end else if (scan_tick) begin
      active_set <= sel_code;
    end
  end
  assign cur_def = act_def_r[active_set*3 +: 3];

  // Millisecond tick for hold and unit ok timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 32'h0;
    end else if (ms_tick) begin
      ms_cnt_r <= 32'h0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 32'h1;
    end
  end
  assign ms_tick = (ms_cnt_r >= MS_CYC - 1);

  // Operating state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sfo_pkg::ST_BOOT;
    end else if (internal_error) begin
      state_r <= sfo_pkg::ST_FAULT;
    end else begin
      case (state_r)
        sfo_pkg::ST_BOOT: begin
          if (boot_done) begin
            state_r <= sfo_pkg::ST_READY;
          end
        end
        sfo_pkg::ST_READY: begin
          if (ok_base_r && !host_attached) begin
            state_r <= sfo_pkg::ST_MON;
          end
        end
        sfo_pkg::ST_MON: begin
          if (host_attached) begin
            state_r <= sfo_pkg::ST_CFG;
          end
        end
        sfo_pkg::ST_CFG: begin
          if (!host_attached && wrlow_cnt_r == 32'h0) begin
            state_r <= sfo_pkg::ST_MON;
          end
        end
        default: begin
          state_r <= sfo_pkg::ST_FAULT;
        end
      endcase
    end
  end

  // One minute from supply before readiness may end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_cnt_r <= 32'h0;
      ready_done_r <= 1'b0;
    end else if (!ready_done_r) begin
      if (ready_cnt_r >= READY_CYC - 1) begin
        ready_done_r <= 1'b1;
      end else begin
        ready_cnt_r <= ready_cnt_r + 32'h1;
      end
    end
  end
  assign ready_led = (state_r == sfo_pkg::ST_READY) || (state_r == sfo_pkg::ST_MON) ||
                     (state_r == sfo_pkg::ST_CFG);
  assign fault_led = (state_r == sfo_pkg::ST_FAULT);

  // Host write in configuration drops unit ok for about a second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrlow_cnt_r <= 32'h0;
    end else if (host_wr && state_r == sfo_pkg::ST_CFG) begin
      wrlow_cnt_r <= WRLOW_CYC;
    end else if (wrlow_cnt_r != 32'h0) begin
      wrlow_cnt_r <= wrlow_cnt_r - 32'h1;
    end
  end

  // Unit ok base level; config keeps it as it was
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_base_r <= 1'b0;
    end else begin
      case (state_r)
        sfo_pkg::ST_READY: ok_base_r <= ready_done_r;
        sfo_pkg::ST_MON: ok_base_r <= 1'b1;
        sfo_pkg::ST_CFG: ok_base_r <= ok_base_r;
        default: ok_base_r <= 1'b0;
      endcase
    end
  end

  // Index pulse at the 90 degree measurement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_cnt_r <= 32'h0;
    end else if (index_tick && cfg_r.index_en && state_r == sfo_pkg::ST_MON) begin
      idx_cnt_r <= INDEX_CYC;
    end else if (idx_cnt_r != 32'h0) begin
      idx_cnt_r <= idx_cnt_r - 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_ok_output <= 1'b0;
    end else begin
      unit_ok_output <= ok_base_r && (idx_cnt_r == 32'h0) && (wrlow_cnt_r == 32'h0) &&
                        (state_r != sfo_pkg::ST_FAULT);
    end
  end

  // Unit ok off longer than threshold flags the third state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oklow_ms_r <= 16'h0;
      defined_state3 <= 1'b0;
    end else if (unit_ok_output) begin
      oklow_ms_r <= 16'h0;
      defined_state3 <= 1'b0;
    end else if (ms_tick) begin
      if (oklow_ms_r >= `SFO_OKLOW_MS) begin
        defined_state3 <= 1'b1;
      end else begin
        oklow_ms_r <= oklow_ms_r + 16'h1;
      end
    end
  end

  // Per field: confirm hit, hold, release
  for (genvar f = 0; f < 3; f++) begin : g_fld
    logic prev_hit_r;
    logic [15:0] hold_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        prev_hit_r <= 1'b0;
      end else if (scan_tick) begin
        prev_hit_r <= field_hit[f];
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        alarm_r[f] <= 1'b1;
        hold_r <= 16'h0;
      end else if (!cur_def[f]) begin
        alarm_r[f] <= 1'b1;
        hold_r <= 16'h0;
      end else if (scan_tick && field_hit[f] && (prev_hit_r || !cfg_r.filter_en)) begin
        alarm_r[f] <= 1'b1;
        hold_r <= 16'h0;
      end else if (alarm_r[f] && ms_tick && !field_hit[f]) begin
        if (hold_r >= cfg_r.hold_ms) begin
          alarm_r[f] <= 1'b0;
          hold_r <= 16'h0;
        end else begin
          hold_r <= hold_r + 16'h1;
        end
      end
    end
  end

  // Outputs low means infringed; forced low outside monitoring and configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 3'h0;
    end else if (state_r != sfo_pkg::ST_MON && state_r != sfo_pkg::ST_CFG) begin
      out_r <= 3'h0;
    end else begin
      out_r <= ~alarm_r;
    end
  end
  assign inner_field_alarm_output = out_r[0];
  assign middle_field_alarm_output = out_r[1];
  assign outer_field_alarm_output = out_r[2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence seq_cfg_write;
    host_wr && state_r == sfo_pkg::ST_CFG;
  endsequence
  sequence seq_fast_hit;
    scan_tick && field_hit[1] && !cfg_r.filter_en && cur_def[1];
  endsequence
  AST_BOOT_EXIT: assert property (
    state_r == sfo_pkg::ST_BOOT |=> state_r inside {sfo_pkg::ST_BOOT, sfo_pkg::ST_READY,
                                                    sfo_pkg::ST_FAULT})
    else $error("boot left to a wrong state");
  AST_FAULT_LOW: assert property (
    internal_error |=> state_r == sfo_pkg::ST_FAULT ##1 !unit_ok_output)
    else $error("fault did not drop unit ok");
  AST_WRITE_LOW: assert property (
    seq_cfg_write |=> ##1 !unit_ok_output [*8])
    else $error("host write did not hold unit ok low");
  AST_HIT_OFF: assert property (
    seq_fast_hit |=> ##1 !middle_field_alarm_output)
    else $error("infringed field output still high");
  AST_SET_TAKE: assert property (
    scan_tick |=> active_set == $past(sel_code))
    else $error("field set not taken at scan");
  AST_NOT_MON_LOW: assert property (
    state_r inside {sfo_pkg::ST_BOOT, sfo_pkg::ST_READY, sfo_pkg::ST_FAULT} |=> out_r == 3'h0)
    else $error("field output high outside monitoring");
  AST_PUSH_ONLY: assert property (
    !push_r |=> $stable(act_def_r))
    else $error("field geometry changed without push");
  AST_COMMIT: assert property (
    nvm_commit |-> $past(wr_en) && $past(paddr) == `SFO_OFF_CTRL)
    else $error("commit without control write");
  AST_UNDEF_LOW: assert property (
    (state_r == sfo_pkg::ST_MON && !cur_def[1]) ##1 (state_r == sfo_pkg::ST_MON)
      |=> !middle_field_alarm_output)
    else $error("undefined field output released");
  AST_MON_ENTRY: assert property (
    state_r == sfo_pkg::ST_READY && ok_base_r && !host_attached && !internal_error
      |=> state_r == sfo_pkg::ST_MON)
    else $error("monitoring not entered");
endmodule

// [test/sfo_machine_model.sv]
// Purpose: Downstream machine controller that selects field sets and watches unit ok.
// Assumes: Block outputs are sampled on clk.
// Notes: The set code is held as a steady level; falls of unit ok are counted.
`timescale 1ns/1ps
module sfo_machine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] code,
  input wire logic unit_ok,
  output logic [3:0] sel,
  output int pulses
);
  logic ok_d;

  // Code bit 0 drives the first select input
  assign sel = code;

  // Liveness watch: every fall of unit ok is one pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_d <= 1'b0;
      pulses <= 0;
    end else begin
      ok_d <= unit_ok;
      if (ok_d && !unit_ok) begin
        pulses <= pulses + 1;
      end
    end
  end
endmodule

// [test/safety_field_output_controller_test.sv]
// Purpose: Self-checking bench for the field output controller.
// Assumes: Short counts: ready 200, write low 50, 10 cycles per ms.
// Notes: Scan every 16 cycles; index tick mid-scan.
`timescale 1ns/1ps
`include "sfo_defines.svh"
module safety_field_output_controller_test;
  localparam int SCAN = 16;
  localparam int WRLOW = 50;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sel, code, active_set;
  logic boot_done, internal_error, host_attached, scan_tick, index_tick;
  logic [2:0] field_hit;
  sfo_pkg::sfo_cfg_t cfg;
  logic nvm_commit, a0, a1, a2, unit_ok, ready_led, fault_led, ds3;
  int errors, checked, pulses, commits, scnt, cyc, n, p0;

  sfo_field_ctrl #(.READY_CYC(200), .WRLOW_CYC(WRLOW), .DEBOUNCE_CYC(4), .MS_CYC(10),
    .INDEX_CYC(3)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .set_select_bit0(sel[0]), .set_select_bit1(sel[1]),
    .set_select_bit2(sel[2]), .set_select_bit3(sel[3]), .boot_done(boot_done),
    .internal_error(internal_error), .host_attached(host_attached), .scan_tick(scan_tick),
    .index_tick(index_tick), .field_hit(field_hit), .active_set(active_set), .cfg(cfg),
    .nvm_commit(nvm_commit), .inner_field_alarm_output(a0), .middle_field_alarm_output(a1),
    .outer_field_alarm_output(a2), .unit_ok_output(unit_ok), .ready_led(ready_led),
    .fault_led(fault_led), .defined_state3(ds3));

  sfo_machine_model u_mach (.clk(clk), .rst_n(rst_n), .code(code), .unit_ok(unit_ok),
    .sel(sel), .pulses(pulses));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    scnt <= (scnt == SCAN - 1) ? 0 : scnt + 1;
    scan_tick <= (scnt == 0);
    index_tick <= (scnt == 8);
    cyc <= rst_n ? cyc + 1 : 0;
    if (nvm_commit === 1'b1) begin
      commits <= commits + 1;
    end
  end

  task automatic finish_test();
    $display("TB: counts errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Held request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return unit_ok;
      1: return a0;
      2: return a1;
      3: return a2;
      default: return ds3;
    endcase
  endfunction

  task automatic wait_sig(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, pick(w), v);
        finish_test();
      end
    end
  endtask

  task automatic stat(input logic [4:0] st);
    apb(1'b0, `SFO_OFF_STAT, 32'h0);
    chk(32'(rd[4:0]), 32'(st));
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    code = 4'h0;
    boot_done = 1'b0;
    internal_error = 1'b0;
    host_attached = 1'b0;
    field_hit = 3'h0;
    errors = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'(unit_ok), 32'h0);
    chk(32'({a0, a1, a2}), 32'h0);
    apb(1'b0, `SFO_OFF_CTRL, 32'h0);
    chk(32'(rd[5:0]), 32'h04);
    apb(1'b0, `SFO_OFF_RESP, 32'h0);
    chk(rd, 32'd67);
    apb(1'b0, `SFO_OFF_BLANK, 32'h0);
    chk(rd, 32'd10);
    apb(1'b0, `SFO_OFF_HOLD, 32'h0);
    chk(rd, 32'd10050);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(32'(sl), 32'h1);
    $display("TB: defaults done");
    wait_cyc(20);
    stat(5'h01);
    boot_done <= 1'b1;
    wait_cyc(3);
    stat(5'h02);
    chk(32'(ready_led), 32'h1);
    chk(32'(unit_ok), 32'h0);
    wait_sig(0, 1'b1, 300);
    chk(32'(cyc >= 200), 32'h1);
    wait_cyc(4);
    stat(5'h04);
    $display("TB: boot done");
    wait_cyc(3 * SCAN);
    chk(32'({a0, a1, a2}), 32'h0);
    apb(1'b1, `SFO_OFF_FDEF, 32'h70);
    apb(1'b1, `SFO_OFF_FDEF, 32'h65);
    apb(1'b1, `SFO_OFF_HOLD, 32'h2);
    apb(1'b0, `SFO_OFF_HOLD, 32'h0);
    chk(rd, 32'h2);
    wait_cyc(3 * SCAN);
    chk(32'({a0, a1, a2}), 32'h0);
    apb(1'b1, `SFO_OFF_CTRL, 32'h14);
    wait_sig(1, 1'b1, 3 * SCAN);
    wait_sig(3, 1'b1, SCAN);
    chk(32'({a0, a1, a2}), 32'h7);
    field_hit <= 3'h2;
    wait_sig(2, 1'b0, 2 * SCAN + 3);
    chk(32'({a0, a2}), 32'h3);
    field_hit <= 3'h0;
    wait_cyc(15);
    chk(32'(a1), 32'h0);
    wait_sig(2, 1'b1, 80);
    $display("TB: fields done");
    apb(1'b1, `SFO_OFF_CTRL, 32'h5);
    field_hit <= 3'h4;
    wait_cyc(SCAN);
    chk(32'(cfg.filter_en), 32'h1);
    field_hit <= 3'h0;
    wait_cyc(4);
    chk(32'(a2), 32'h1);
    field_hit <= 3'h4;
    wait_sig(3, 1'b0, 3 * SCAN);
    field_hit <= 3'h0;
    wait_sig(3, 1'b1, 80);
    $display("TB: filter done");
    code <= 4'h5;
    wait_sig(1, 1'b0, 3 * SCAN + 12);
    chk(32'(active_set), 32'h5);
    chk(32'({a1, a2}), 32'h3);
    code <= 4'h7;
    wait_cyc(2);
    code <= 4'h5;
    wait_cyc(3 * SCAN);
    chk(32'(active_set), 32'h5);
    apb(1'b0, `SFO_OFF_STAT, 32'h0);
    chk(32'(rd[14:11]), 32'h5);
    apb(1'b1, `SFO_OFF_CTRL, 32'h25);
    wait_cyc(2 * SCAN);
    chk(32'(active_set), 32'ha);
    apb(1'b1, `SFO_OFF_CTRL, 32'h5);
    wait_cyc(2 * SCAN);
    chk(32'(active_set), 32'h5);
    $display("TB: set select done");
    p0 = pulses;
    wait_cyc(4 * SCAN);
    chk(32'(pulses - p0), 32'h4);
    apb(1'b1, `SFO_OFF_CTRL, 32'h0);
    wait_cyc(SCAN);
    p0 = pulses;
    wait_cyc(4 * SCAN);
    chk(32'(pulses - p0), 32'h0);
    p0 = commits;
    apb(1'b1, `SFO_OFF_CTRL, 32'h8);
    wait_cyc(3);
    chk(32'(commits - p0), 32'h1);
    $display("TB: index and commit done");
    host_attached <= 1'b1;
    wait_cyc(4);
    stat(5'h08);
    chk(32'(unit_ok), 32'h1);
    apb(1'b1, `SFO_OFF_RESP, 32'h64);
    wait_cyc(3);
    chk(32'(cfg.resp_ms), 32'h64);
    chk(32'(unit_ok), 32'h0);
    wait_sig(0, 1'b1, 2 * WRLOW);
    chk(32'(n > WRLOW - 6), 32'h1);
    host_attached <= 1'b0;
    wait_cyc(4);
    stat(5'h04);
    $display("TB: config done");
    chk(32'(ds3), 32'h0);
    internal_error <= 1'b1;
    wait_cyc(4);
    chk(32'(unit_ok), 32'h0);
    chk(32'({a0, a1, a2}), 32'h0);
    chk(32'(fault_led), 32'h1);
    stat(5'h10);
    wait_cyc(600);
    chk(32'(ds3), 32'h0);
    wait_sig(4, 1'b1, 100);
    $display("TB: fault done");
    finish_test();
  end
endmodule
